// ### hw/ldc_pkg.sv
// package for the low-latency memory command decoder
package ldc_pkg;
  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 20;
  localparam int BANK_W = 4;
  localparam int MASK_W = 2;
  localparam int NUM_CFG = 3;
  // ----------------------------------------
  // mode register field positions and reset values
  // ----------------------------------------
  localparam int WR_MODE_LO = 3; // two-bit write bank mode field in cfg_reg_two
  localparam int RF_MODE_BIT = 5; // refresh method bit in cfg_reg_two
  localparam logic [19:0] CFG_RESET = 20'h00000;
  localparam logic [1:0] WR_SINGLE = 2'h0;
  localparam logic [1:0] WR_DUAL = 2'h1;
  localparam logic [1:0] WR_QUAD = 2'h2;
  localparam logic [1:0] CFG_SEL_ZERO = 2'h0;
  localparam logic [1:0] CFG_SEL_ONE = 2'h1;
  localparam logic [1:0] CFG_SEL_TWO = 2'h2;

  // decoded command, gray coded along idle -> read -> write -> refresh -> load
  typedef enum logic [2:0] {
    LDC_IDLE = 3'h0,
    LDC_READ = 3'h1,
    LDC_WRITE = 3'h3,
    LDC_RFSH = 3'h2,
    LDC_LOAD = 3'h6
  } ldc_cmd_type;

  // command pins from the controller
  typedef struct packed {
    logic chip_sel_n;
    logic write_en_n;
    logic rfsh_n;
    logic [19:0] addr;
    logic [3:0] bank;
  } ldc_pins_type;

  // operation request handed to the array
  typedef struct packed {
    ldc_cmd_type cmd;
    logic [15:0] banks; // one-hot or multi-hot target banks
    logic [19:0] addr;
  } ldc_op_type;
endpackage : ldc_pkg

// ### hw/ldc_bank_sel.sv
// bank target expansion for reads, writes and refreshes
module ldc_bank_sel (
  // decoded command
  input wire ldc_pkg::ldc_cmd_type cmd,
  input wire logic [3:0] bank,
  input wire logic [19:0] addr,
  // mode settings
  input wire logic [1:0] wr_mode,
  input wire logic rf_multi,
  // result
  output logic [15:0] banks
);
  logic [3:0] keep;
  // --------------------------------
  // per-bank match
  // --------------------------------
  // dual writes use bank[2:0] and quad bank[1:0]; the unused top bits fan the write out
  always_comb begin
    unique case (wr_mode)
      ldc_pkg::WR_DUAL: keep = 4'h7;
      ldc_pkg::WR_QUAD: keep = 4'h3;
      default: keep = 4'hF;
    endcase
  end
  for (genvar b = 0; b < 16; b++) begin : g_bank
    always_comb begin
      banks[b] = 1'b0;
      unique case (cmd)
        ldc_pkg::LDC_READ: banks[b] = (bank == 4'(b));
        ldc_pkg::LDC_WRITE: banks[b] = ((bank & keep) == (4'(b) & keep));
        ldc_pkg::LDC_RFSH:
          // multibank takes the whole target set from address bits [15:0]
          if (rf_multi) banks[b] = addr[b];
          else banks[b] = (bank == 4'(b));
        default: banks[b] = 1'b0;
      endcase
    end
  end
endmodule // ldc_bank_sel

// ### hw/ldc_decoder.sv
// command decoder and mode register file
// Functional notes
// - sample commands on rising clock only
// - chip select high is idle, nothing starts
// - decode write enable and refresh strobe
// - mode load stores address, bank picks register
// - mode registers hold until reload or reset
// - read targets one bank and location
// - write targets one, two or four banks
// - masked write portions are discarded
// - single or multibank refresh by mode
// - refresh uses bank or address inputs only
module ldc_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // command and address pins
  input wire ldc_pkg::ldc_pins_type pins,
  input wire logic [1:0] write_mask,
  // operation towards the array
  output ldc_pkg::ldc_op_type op,
  output logic op_valid,
  output logic [1:0] write_keep,
  // mode register contents
  output logic [19:0] cfg_reg_zero,
  output logic [19:0] cfg_reg_one,
  output logic [19:0] cfg_reg_two
);
  typedef struct packed {
    ldc_pkg::ldc_op_type op;
    logic op_valid;
    logic [1:0] keep;
    logic [19:0] cfg0;
    logic [19:0] cfg1;
    logic [19:0] cfg2;
  } ldc_state_type;

  ldc_state_type state_reg;
  ldc_state_type state_next;
  ldc_pkg::ldc_cmd_type cmd;
  logic [15:0] banks;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // pins are sampled once per rising edge; nothing is latched mid-cycle
  always_comb begin
    if (pins.chip_sel_n) cmd = ldc_pkg::LDC_IDLE;
    else begin
      unique case ({pins.write_en_n, pins.rfsh_n})
        2'h0: cmd = ldc_pkg::LDC_LOAD;
        2'h1: cmd = ldc_pkg::LDC_WRITE;
        2'h3: cmd = ldc_pkg::LDC_READ;
        2'h2: cmd = ldc_pkg::LDC_RFSH;
      endcase
    end
  end

  ldc_bank_sel u_bank_sel (
    .cmd(cmd),
    .bank(pins.bank),
    .addr(pins.addr),
    .wr_mode(state_reg.cfg2[ldc_pkg::WR_MODE_LO +: 2]),
    .rf_multi(state_reg.cfg2[ldc_pkg::RF_MODE_BIT]),
    .banks(banks)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // the op register is one cycle deep; earlier ops belong to the array and are
  // never cancelled by an idle cycle
  always_comb begin
    state_next = state_reg;
    state_next.op.cmd = cmd;
    state_next.op.banks = banks;
    // refresh in multibank mode ignores the bank pins, single ignores address
    state_next.op.addr = (cmd == ldc_pkg::LDC_RFSH) ? 20'h00000 : pins.addr;
    state_next.op_valid = (cmd != ldc_pkg::LDC_IDLE) && (cmd != ldc_pkg::LDC_LOAD);
    // mask low means write that portion
    state_next.keep = (cmd == ldc_pkg::LDC_WRITE) ? ~write_mask : 2'h0;
    if (cmd == ldc_pkg::LDC_LOAD) begin
      unique case (pins.bank[1:0])
        ldc_pkg::CFG_SEL_ZERO: state_next.cfg0 = pins.addr;
        ldc_pkg::CFG_SEL_ONE: state_next.cfg1 = pins.addr;
        ldc_pkg::CFG_SEL_TWO: state_next.cfg2 = pins.addr;
        default: state_next.cfg0 = state_reg.cfg0; // select 3 has no register
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg.op <= '{cmd: ldc_pkg::LDC_IDLE, banks: 16'h0000, addr: 20'h00000};
      state_reg.op_valid <= 1'b0;
      state_reg.keep <= 2'h0;
      state_reg.cfg0 <= ldc_pkg::CFG_RESET;
      state_reg.cfg1 <= ldc_pkg::CFG_RESET;
      state_reg.cfg2 <= ldc_pkg::CFG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign op = state_reg.op;
  assign op_valid = state_reg.op_valid;
  assign write_keep = state_reg.keep;
  assign cfg_reg_zero = state_reg.cfg0;
  assign cfg_reg_one = state_reg.cfg1;
  assign cfg_reg_two = state_reg.cfg2;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_idle_no_op: assert property (@(posedge clock) disable iff (!reset_n)
    pins.chip_sel_n |=> !op_valid) else $error("idle cycle started an op");
  a_decode_read: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && pins.write_en_n && pins.rfsh_n) |=> op.cmd == ldc_pkg::LDC_READ)
    else $error("read not decoded");
  a_load_stores: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && !pins.rfsh_n && pins.bank[1:0] == 2'h1)
    |=> cfg_reg_one == $past(pins.addr)) else $error("mode load lost");
  a_cfg_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (pins.chip_sel_n || pins.write_en_n || pins.rfsh_n) |=> $stable(cfg_reg_two))
    else $error("mode register changed");
  a_read_bank: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && pins.write_en_n && pins.rfsh_n)
    |=> op.banks == (16'h0001 << $past(pins.bank)) && op.addr == $past(pins.addr))
    else $error("read bank wrong");
  a_write_count: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op.cmd == ldc_pkg::LDC_WRITE && cfg_reg_two[4:3] == 2'h2)
    |-> $countones(op.banks) == 4) else $error("quad write bank count");
  a_mask_keep: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n)
    |=> write_keep == ~$past(write_mask)) else $error("write mask wrong");
  a_rfsh_single: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && pins.write_en_n && !pins.rfsh_n && !cfg_reg_two[5])
    |=> op.banks == (16'h0001 << $past(pins.bank))) else $error("refresh bank wrong");
  a_rfsh_multi: assert property (@(posedge clock) disable iff (!reset_n)
    (op_valid && op.cmd == ldc_pkg::LDC_RFSH && cfg_reg_two[5] && $stable(cfg_reg_two))
    |-> op.banks == $past(pins.addr[15:0])) else $error("multibank refresh wrong");

  // ----------------------------------------
  // decode checks
  // ----------------------------------------
  // every selected code lands in the op register one edge later; a mode load must
  // never reach the array, since the array has no use for a register opcode
  a_decode_write: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n)
    |=> op_valid && op.cmd == ldc_pkg::LDC_WRITE) else $error("write not decoded");
  a_decode_rfsh: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && pins.write_en_n && !pins.rfsh_n)
    |=> op_valid && op.cmd == ldc_pkg::LDC_RFSH) else $error("refresh not decoded");
  a_load_no_op: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && !pins.rfsh_n)
    |=> !op_valid) else $error("mode load reached the array");
  // a pulse must always carry an array command, never the idle or load code
  a_op_kind: assert property (@(posedge clock) disable iff (!reset_n)
    op_valid |-> (op.cmd != ldc_pkg::LDC_IDLE) && (op.cmd != ldc_pkg::LDC_LOAD))
    else $error("op pulse without an array command");

  // ----------------------------------------
  // mode register checks
  // ----------------------------------------
  // only the register picked by bank[1:0] moves; select 3 names no register at all
  a_load_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && !pins.rfsh_n
      && pins.bank[1:0] == ldc_pkg::CFG_SEL_ZERO)
    |=> cfg_reg_zero == $past(pins.addr) && $stable(cfg_reg_one))
    else $error("mode load to register zero lost");
  a_load_two: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && !pins.rfsh_n
      && pins.bank[1:0] == ldc_pkg::CFG_SEL_TWO)
    |=> cfg_reg_two == $past(pins.addr) && $stable(cfg_reg_zero))
    else $error("mode load to register two lost");
  a_load_spare: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && !pins.rfsh_n
      && pins.bank[1:0] == 2'h3)
    |=> $stable(cfg_reg_zero) && $stable(cfg_reg_one) && $stable(cfg_reg_two))
    else $error("unused mode select changed a register");
  // anything but a mode load, idle cycles included, must leave the settings alone
  a_cfg_keep: assert property (@(posedge clock) disable iff (!reset_n)
    (pins.chip_sel_n || pins.write_en_n || pins.rfsh_n)
    |=> $stable(cfg_reg_zero) && $stable(cfg_reg_one)) else $error("mode register drifted");
  // reset is synchronous, so the cleared values show one edge after reset is seen low
  a_reset_clear: assert property (@(posedge clock)
    !reset_n |=> (cfg_reg_zero == ldc_pkg::CFG_RESET) && (cfg_reg_one == ldc_pkg::CFG_RESET)
      && (cfg_reg_two == ldc_pkg::CFG_RESET) && !op_valid)
    else $error("reset left state behind");

  // ----------------------------------------
  // bank target checks
  // ----------------------------------------
  // the named bank is always a target; dual and quad writes add the banks that differ
  // only in the bank bits above the ones the mode uses
  a_write_home: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n)
    |=> op.banks[$past(pins.bank)] && op.addr == $past(pins.addr))
    else $error("write missed its own bank");
  a_write_single: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n
      && cfg_reg_two[ldc_pkg::WR_MODE_LO +: 2] == ldc_pkg::WR_SINGLE)
    |=> op.banks == (16'h0001 << $past(pins.bank))) else $error("single write banks wrong");
  a_write_dual: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n
      && cfg_reg_two[ldc_pkg::WR_MODE_LO +: 2] == ldc_pkg::WR_DUAL)
    |=> op.banks == (16'h0101 << $past(pins.bank[2:0]))) else $error("dual write banks wrong");
  a_write_quad: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n
      && cfg_reg_two[ldc_pkg::WR_MODE_LO +: 2] == ldc_pkg::WR_QUAD)
    |=> op.banks == (16'h1111 << $past(pins.bank[1:0]))) else $error("quad write banks wrong");

  // ----------------------------------------
  // array handoff checks
  // ----------------------------------------
  // the keep mask only means something beside a write; refresh carries no location
  a_keep_clear: assert property (@(posedge clock) disable iff (!reset_n)
    !(!pins.chip_sel_n && !pins.write_en_n && pins.rfsh_n)
    |=> write_keep == 2'h0) else $error("keep mask outside a write");
  a_rfsh_addr: assert property (@(posedge clock) disable iff (!reset_n)
    (!pins.chip_sel_n && pins.write_en_n && !pins.rfsh_n)
    |=> op.addr == 20'h00000) else $error("refresh carried a location");
endmodule // ldc_decoder

// ### testbench/ldc_ctl_model.sv
// memory controller model driving the decoder's command pins
module ldc_ctl_model #(
  parameter int ROW_CYCLES = 4,
  parameter int LOAD_WAIT = 6
) (
  // clock
  input wire logic clock,
  // command pins
  output ldc_pkg::ldc_pins_type pins,
  output logic [1:0] write_mask
);
  timeunit 1ns;
  timeprecision 100ps;
  int cyc = 0;
  int last [16];
  // free cycle count, used to space commands to one bank
  always @(posedge clock) cyc <= cyc + 1;
  initial begin
    pins = '1;
    write_mask = 2'h3;
    foreach (last[i]) last[i] = -100;
  end
  // deselected pins toggle so stale values never look valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      pins.chip_sel_n = 1'b1;
      pins.addr = ~pins.addr;
      pins.bank = ~pins.bank;
    end
  endtask
  // exactly one command per call, never repeated by the model itself
  task automatic issue(input logic [2:0] code, input logic [3:0] b, input logic [19:0] a,
    input logic [1:0] m);
    if (code == 3'h0) idle(ROW_CYCLES);
    while (code[2] == 1'b0 && code != 3'h0 && cyc - last[b] < ROW_CYCLES) idle(1);
    @(posedge clock);
    #1;
    pins = {code, a, b};
    write_mask = m;
    last[b] = cyc;
    if (code == 3'h0) idle(LOAD_WAIT);
  endtask
endmodule // ldc_ctl_model

// ### testbench/lowlat_dram_cmd_decoder_tb.sv
// self-checking bench for the command decoder
module lowlat_dram_cmd_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  ldc_pkg::ldc_pins_type pins;
  ldc_pkg::ldc_op_type op;
  logic [1:0] write_mask;
  logic [1:0] write_keep;
  logic op_valid;
  logic [19:0] cfg_reg_zero, cfg_reg_one, cfg_reg_two;
  logic [19:0] cfg_exp [3] = '{default: 20'h00000};
  logic [63:0] exp_q [$];
  logic [31:0] seed = 32'h000175D8;
  logic [31:0] r;
  int error_cnt = 0;
  int num_checks = 0;
  always #2 clock = ~clock;
  ldc_ctl_model i_ctl (.clock(clock), .pins(pins), .write_mask(write_mask));
  ldc_decoder i_dut (.clock(clock), .reset_n(reset_n), .pins(pins), .write_mask(write_mask),
    .op(op), .op_valid(op_valid), .write_keep(write_keep), .cfg_reg_zero(cfg_reg_zero),
    .cfg_reg_one(cfg_reg_one), .cfg_reg_two(cfg_reg_two));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    num_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_cfg();
    check({cfg_reg_zero, cfg_reg_one, cfg_reg_two}, {cfg_exp[0], cfg_exp[1], cfg_exp[2]});
  endtask
  // mode load; bank 3 names no register and must change nothing
  task automatic load(input logic [1:0] b, input logic [19:0] v);
    i_ctl.issue(3'h0, {2'h0, b}, v, 2'h3);
    if (b != 2'h3) cfg_exp[b] = v;
    check_cfg();
  endtask
  // expectation is noted before the sampling edge, so it is always queued first
  task automatic send(input logic [2:0] code, input logic [3:0] b, input logic [19:0] a,
    input logic [1:0] m);
    logic [15:0] bk;
    bk = 16'h0001 << b;
    if (code == 3'h1 && cfg_exp[2][4:3] == ldc_pkg::WR_DUAL) bk = 16'h0101 << b[2:0];
    if (code == 3'h1 && cfg_exp[2][4:3] == ldc_pkg::WR_QUAD) bk = 16'h1111 << b[1:0];
    if (code == 3'h2 && cfg_exp[2][5]) bk = a[15:0];
    i_ctl.issue(code, b, a, m);
    if (code == 3'h3) exp_q.push_back({23'h0, ldc_pkg::LDC_READ, bk, a, 2'h0});
    if (code == 3'h1) exp_q.push_back({23'h0, ldc_pkg::LDC_WRITE, bk, a, ~m});
    if (code == 3'h2) exp_q.push_back({23'h0, ldc_pkg::LDC_RFSH, bk, 20'h00000, 2'h0});
  endtask
  // each result takes the oldest note; a result with no note never matches
  always @(posedge clock) begin
    if (op_valid === 1'b1) begin
      if (exp_q.size() == 0) check({23'h0, op, write_keep}, '1);
      else check({23'h0, op, write_keep}, exp_q.pop_front());
    end
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1'b1;
    check_cfg();
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      load(k[1:0], r[19:0]);
    end
    for (int wm = 0; wm < 3; wm++) begin
      for (int rf = 0; rf < 2; rf++) begin
        r = rnd();
        r[5:3] = {rf[0], wm[1:0]};
        load(2'h2, r[19:0]);
        repeat (24) begin
          r = rnd();
          if (r[2:0] == 3'h0) r[2:0] = 3'h4;
          send(r[2:0], r[6:3], r[26:7], r[28:27]);
        end
      end
    end
    i_ctl.idle(3);
    reset_n = 1'b0;
    @(posedge clock);
    #1;
    reset_n = 1'b1;
    cfg_exp = '{default: 20'h00000};
    check_cfg();
    check(exp_q.size(), 64'h0);
    stop_test();
  end
endmodule // lowlat_dram_cmd_decoder_tb
